// ===== include/synth_regs_pkg.sv
/*
 * Shared constants of the synthesiser separation and lock register bank:
 * register offsets, field positions, reset values and lock filter thresholds.
 * Assumes an 8-bit register port addressed by byte offset.
 */
package synth_regs_pkg;

    // ========================================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEP_W = 11;
    localparam int SEP_LOW_W = 8;
    localparam int SEP_HIGH_W = 3;
    localparam int DIV_W = 5;
    localparam int LOCK_CNT_W = 7;

    // ========================================================================
    // register offsets
    localparam logic [7:0] OFS_SYNTH_CONTROL = 8'hE3;
    localparam logic [7:0] OFS_LOCK_STATUS = 8'hE4;
    localparam logic [7:0] OFS_SEPARATION_LOW = 8'hEA;
    localparam logic [7:0] OFS_SEPARATION_HIGH = 8'hEB;

    // ========================================================================
    // reset values
    localparam logic [7:0] RST_SEP_LOW = 8'h59;
    localparam logic [2:0] RST_SEP_HIGH = 3'h0;
    localparam logic [4:0] RST_REF_DIV = 5'h02;
    localparam logic RST_ALARM_DIS = 1'h0;
    localparam logic RST_ACC_SEL = 1'h0;
    localparam logic RST_WIN_LEN = 1'h0;

    // ========================================================================
    // field positions
    localparam int CTRL_DIV_LSB = 3;
    localparam int CTRL_ALARM_DIS_BIT = 2;
    localparam int CTRL_ALARM_H_BIT = 1;
    localparam int CTRL_ALARM_L_BIT = 0;
    localparam int LOCK_ACC_BIT = 3;
    localparam int LOCK_LEN_BIT = 2;
    localparam int LOCK_INST_BIT = 1;
    localparam int LOCK_CONT_BIT = 0;

    // ========================================================================
    // reference divider range
    localparam logic [4:0] REF_DIV_MIN = 5'h02;
    localparam logic [4:0] REF_DIV_MAX = 5'h18;

    // ========================================================================
    // continuous lock thresholds: fine (select 0) and coarse (select 1)
    localparam logic [6:0] LOCK_SET_FINE = 7'h7F;
    localparam logic [6:0] LOCK_RST_FINE = 7'h6F;
    localparam logic [6:0] LOCK_SET_COARSE = 7'h1F;
    localparam logic [6:0] LOCK_RST_COARSE = 7'h0F;

endpackage

// ===== verilog/lock_filter.sv
/*
 * Continuous lock filter: counts in-lock samples up and out-of-lock samples
 * down, raising a flag at the set threshold and dropping it below the reset
 * threshold. Assumes samples arrive as one-cycle valid pulses on mclk.
 */
`timescale 1ns/1ns
module lock_filter
    import synth_regs_pkg::*;
#(
    parameter int CNT_W = LOCK_CNT_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic sample_in_lock,
    input wire logic acc_sel,
    output logic lock_flag
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic flag;
    } filt_s;

    filt_s s_q, s_d;
    logic [CNT_W-1:0] set_thr, rst_thr;

    generate
        if (CNT_W < LOCK_CNT_W) begin : g_bad_width
            $error("lock filter counter too narrow for the thresholds");
        end
    endgenerate

    // ========================================================================
    // threshold select
    // threshold pair pick
    assign set_thr = acc_sel ? CNT_W'(LOCK_SET_COARSE) : CNT_W'(LOCK_SET_FINE);
    assign rst_thr = acc_sel ? CNT_W'(LOCK_RST_COARSE) : CNT_W'(LOCK_RST_FINE);

    // ========================================================================
    // counter and flag
    always_comb begin
        s_d = s_q;
        if (sample_valid) begin
            if (sample_in_lock) begin
                if (s_q.cnt < set_thr) begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end else begin
                    s_d.cnt = set_thr;
                end
            end else if (s_q.cnt != '0) begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end
        if (s_d.cnt >= set_thr) begin
            s_d.flag = 1'b1;
        end else if (s_d.cnt < rst_thr) begin
            s_d.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lock_flag = s_q.flag;

    // ========================================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    lock_set_a: assert property (
        sample_valid && sample_in_lock && !acc_sel && s_q.cnt == CNT_W'(126)
        |=> lock_flag)
        else $error("lock flag not set at fine set threshold");

    lock_clear_a: assert property (
        sample_valid && !sample_in_lock && acc_sel && s_q.cnt == CNT_W'(15)
        && $stable(acc_sel) |=> !lock_flag)
        else $error("lock flag not cleared below coarse reset threshold");

    lock_hyst_a: assert property (
        lock_flag && sample_valid && !sample_in_lock && !acc_sel
        && s_q.cnt == CNT_W'(112) |=> lock_flag)
        else $error("lock flag dropped above the reset threshold");

    lock_rise_c: cover property ($rose(lock_flag));
    lock_fall_c: cover property ($fell(lock_flag));

endmodule

// ===== verilog/synth_separation_lock_regs.sv
/*
 * Register bank of the frequency synthesiser: separation word, reference
 * divider, tuning alarms and lock detector status.
 * Assumes a plain register port on mclk with read data one cycle after the
 * read strobe; tuning comparators and lock window come from analogue pins.
 */
// What this block does
// - upper separation register holds word bits 10:8; bits 7:3 read zero; reset zero
// - lower separation register holds word bits 7:0, read/write, reset 0x59
// - control bits 7:3 hold reference divider, reset 2, dividing crystal clock
// - control bit 2 set suppresses both tuning alarms; clear enables them
// - control bit 1 flags tuning voltage too near supply, read only
// - control bit 0 flags tuning voltage too near ground, read only
// - lock bit 1 is one lock window sample per reference tick
// - lock bit 0 is the filtered continuous lock flag
// - accuracy select 0 uses set threshold 127, reset threshold 111
// - accuracy select 1 uses set threshold 31, reset threshold 15
// - lock bit 2 is stored and read back but selects nothing, software keeps it 0; bits 7:4 zero
// - transmit with data one adds separation word; otherwise nothing added
`timescale 1ns/1ns
module synth_separation_lock_regs
    import synth_regs_pkg::*;
#(
    parameter int FILT_CNT_W = LOCK_CNT_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic tune_high_pin,
    input wire logic tune_low_pin,
    input wire logic lock_window_pin,
    input wire logic tx_mode,
    input wire logic transmit_bit,
    output logic [SEP_W-1:0] separation_word,
    output logic [SEP_W-1:0] freq_offset,
    output logic [DIV_W-1:0] reference_divider,
    output logic ref_tick,
    output logic lock_continuous
);

    // ========================================================================
    // state
    typedef struct packed {
        logic [SEP_HIGH_W-1:0] sep_high;
        logic [SEP_LOW_W-1:0] sep_low;
        logic [DIV_W-1:0] ref_div;
        logic alarm_dis;
        logic acc_sel;
        logic win_len;
        logic [1:0] tune_hi_sync;
        logic [1:0] tune_lo_sync;
        logic [1:0] lock_sync;
        logic alarm_h;
        logic alarm_l;
        logic lock_inst;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic [SEP_W-1:0] offset;
        logic [DATA_W-1:0] rdata;
    } regs_s;

    regs_s s_q, s_d;
    logic [DIV_W-1:0] div_eff;
    logic filt_flag;

    generate
        if (SEP_W != SEP_HIGH_W + SEP_LOW_W) begin : g_bad_sep
            $error("separation word width does not match its two registers");
        end
    endgenerate

    // ========================================================================
    // address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ========================================================================
    // continuous lock filter
    lock_filter #(
        .CNT_W(FILT_CNT_W)
    ) u_filter (
        .mclk(mclk),
        .nrst(nrst),
        .sample_valid(s_q.tick),
        .sample_in_lock(s_q.lock_sync[1]),
        .acc_sel(s_q.acc_sel),
        .lock_flag(filt_flag)
    );

    // divider values below the minimum behave as the minimum
    assign div_eff = (s_q.ref_div < REF_DIV_MIN) ? REF_DIV_MIN : s_q.ref_div;

    // ========================================================================
    // next state
    always_comb begin
        s_d = s_q;

        // pin synchronisers
        s_d.tune_hi_sync = {s_q.tune_hi_sync[0], tune_high_pin};
        s_d.tune_lo_sync = {s_q.tune_lo_sync[0], tune_low_pin};
        s_d.lock_sync = {s_q.lock_sync[0], lock_window_pin};

        // register writes
        if (reg_wr) begin
            if (hit(reg_addr, OFS_SEPARATION_HIGH)) begin
                s_d.sep_high = reg_wdata[SEP_HIGH_W-1:0];
            end
            if (hit(reg_addr, OFS_SEPARATION_LOW)) begin
                s_d.sep_low = reg_wdata;
            end
            if (hit(reg_addr, OFS_SYNTH_CONTROL)) begin
                s_d.ref_div = reg_wdata[CTRL_DIV_LSB +: DIV_W];
                s_d.alarm_dis = reg_wdata[CTRL_ALARM_DIS_BIT];
            end
            if (hit(reg_addr, OFS_LOCK_STATUS)) begin
                s_d.acc_sel = reg_wdata[LOCK_ACC_BIT];
                s_d.win_len = reg_wdata[LOCK_LEN_BIT];
            end
        end

        if (s_q.div_cnt >= div_eff - 1'b1) begin
            s_d.div_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 1'b1;
            s_d.tick = 1'b0;
        end

        s_d.alarm_h = s_q.tune_hi_sync[1] & ~s_q.alarm_dis;
        s_d.alarm_l = s_q.tune_lo_sync[1] & ~s_q.alarm_dis;

        // one lock window sample per tick
        if (s_q.tick) begin
            s_d.lock_inst = s_q.lock_sync[1];
        end

        // separation added only for a transmitted one
        if (tx_mode && transmit_bit) begin
            s_d.offset = {s_q.sep_high, s_q.sep_low};
        end else begin
            s_d.offset = '0;
        end

        // register reads, unmapped addresses read zero
        s_d.rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, OFS_SEPARATION_HIGH)) begin
                s_d.rdata[SEP_HIGH_W-1:0] = s_q.sep_high;
            end
            if (hit(reg_addr, OFS_SEPARATION_LOW)) begin
                s_d.rdata = s_q.sep_low;
            end
            // alarms masked at once by the disable
            if (hit(reg_addr, OFS_SYNTH_CONTROL)) begin
                s_d.rdata[CTRL_DIV_LSB +: DIV_W] = s_q.ref_div;
                s_d.rdata[CTRL_ALARM_DIS_BIT] = s_q.alarm_dis;
                s_d.rdata[CTRL_ALARM_H_BIT] = s_q.alarm_h & ~s_q.alarm_dis;
                s_d.rdata[CTRL_ALARM_L_BIT] = s_q.alarm_l & ~s_q.alarm_dis;
            end
            if (hit(reg_addr, OFS_LOCK_STATUS)) begin
                s_d.rdata[LOCK_ACC_BIT] = s_q.acc_sel;
                s_d.rdata[LOCK_LEN_BIT] = s_q.win_len;
                s_d.rdata[LOCK_INST_BIT] = s_q.lock_inst;
                s_d.rdata[LOCK_CONT_BIT] = filt_flag;
            end
        end
    end

    // ========================================================================
    // registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.sep_high <= RST_SEP_HIGH;
            s_q.sep_low <= RST_SEP_LOW;
            s_q.ref_div <= RST_REF_DIV;
            s_q.alarm_dis <= RST_ALARM_DIS;
            s_q.acc_sel <= RST_ACC_SEL;
            s_q.win_len <= RST_WIN_LEN;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================================
    // outputs
    assign reg_rdata = s_q.rdata;
    assign separation_word = {s_q.sep_high, s_q.sep_low};
    assign freq_offset = s_q.offset;
    assign reference_divider = s_q.ref_div;
    assign ref_tick = s_q.tick;
    assign lock_continuous = filt_flag;

    // ========================================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sep_high_wr_a: assert property (
        reg_wr && hit(reg_addr, OFS_SEPARATION_HIGH)
        ##1 reg_rd && hit(reg_addr, OFS_SEPARATION_HIGH)
        |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)})
        else $error("upper separation readback wrong");

    sep_low_wr_a: assert property (
        reg_wr && hit(reg_addr, OFS_SEPARATION_LOW)
        |=> separation_word[7:0] == $past(reg_wdata))
        else $error("lower separation write not stored");

    ref_div_wr_a: assert property (
        reg_wr && hit(reg_addr, OFS_SYNTH_CONTROL)
        |=> reference_divider == $past(reg_wdata[7:3]))
        else $error("reference divider write not stored");

    tick_space_a: assert property (
        $rose(ref_tick) && reference_divider == 5'h03 && $stable(reference_divider)
        |=> !ref_tick ##1 !ref_tick ##1 ref_tick)
        else $error("reference tick spacing wrong for divide by three");

    alarm_high_a: assert property (
        (tune_high_pin && !s_q.alarm_dis)[*4] |-> s_q.alarm_h)
        else $error("high tuning alarm not raised");

    alarm_low_a: assert property (
        (tune_low_pin && !s_q.alarm_dis)[*4] |-> s_q.alarm_l)
        else $error("low tuning alarm not raised");

    alarm_off_a: assert property (
        reg_rd && hit(reg_addr, OFS_SYNTH_CONTROL) && s_q.alarm_dis
        |=> reg_rdata[1:0] == 2'h0)
        else $error("disabled alarm read as set");

    lock_inst_a: assert property (
        ref_tick |=> s_q.lock_inst == $past(s_q.lock_sync[1]))
        else $error("instant lock sample not taken on tick");

    lock_read_a: assert property (
        reg_rd && hit(reg_addr, OFS_LOCK_STATUS)
        |=> reg_rdata[7:4] == 4'h0 && reg_rdata[0] == $past(lock_continuous))
        else $error("lock register readback wrong");

    tx_add_a: assert property (
        tx_mode && transmit_bit |=> freq_offset == $past(separation_word))
        else $error("separation not added for a transmitted one");

    rx_zero_a: assert property (
        !tx_mode || !transmit_bit |=> freq_offset == 11'h000)
        else $error("offset added outside a transmitted one");

    alarm_seen_c: cover property (s_q.alarm_h && !s_q.alarm_dis);
    tx_one_c: cover property (tx_mode && transmit_bit ##1 freq_offset != 11'h000);
    lock_read_c: cover property (reg_rd && hit(reg_addr, OFS_LOCK_STATUS) ##1 reg_rdata[0]);

endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench for the synthesiser register bank: register table,
 * tuning alarms, frequency offset, reference tick and continuous lock filter.
 * Assumes the design package is compiled first and the bank runs on mclk only.
 */
`timescale 1ns/1ns
module testbench
    import synth_regs_pkg::*;
;
    logic mclk;
    logic nrst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic tune_high_pin;
    logic tune_low_pin;
    logic lock_window_pin;
    logic tx_mode;
    logic transmit_bit;
    logic [SEP_W-1:0] separation_word;
    logic [SEP_W-1:0] freq_offset;
    logic [DIV_W-1:0] reference_divider;
    logic ref_tick;
    logic lock_continuous;
    int num_errors;
    int comparisons;
    int n;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } row_s;
    row_s rows[6];

    synth_separation_lock_regs dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tune_high_pin(tune_high_pin), .tune_low_pin(tune_low_pin),
        .lock_window_pin(lock_window_pin), .tx_mode(tx_mode), .transmit_bit(transmit_bit),
        .separation_word(separation_word), .freq_offset(freq_offset),
        .reference_divider(reference_divider), .ref_tick(ref_tick),
        .lock_continuous(lock_continuous)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ========================================================================
    // helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(name, {8'h00, reg_rdata}, {8'h00, exp});
        @(posedge mclk);
        #1;
        check("rdata_idle", {8'h00, reg_rdata}, 16'h0000);
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // counts reference ticks until the continuous flag reaches the target
    task automatic ticks_until(input logic target, output int cnt);
        int i;
        cnt = 0;
        for (i = 0; i < 4000 && lock_continuous !== target; i++) begin
            @(posedge mclk);
            #1;
            if (ref_tick === 1'b1) begin
                cnt++;
            end
        end
        if (lock_continuous !== target) begin
            num_errors++;
            $display("ERROR lock_continuous wait expired");
            end_sim();
        end
    endtask

    // ========================================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tune_high_pin = 1'b0;
        tune_low_pin = 1'b0;
        lock_window_pin = 1'b0;
        tx_mode = 1'b0;
        transmit_bit = 1'b0;
        num_errors = 0;
        comparisons = 0;
        rows[0] = '{OFS_SEPARATION_LOW, 8'hA5, 8'hA5};
        rows[1] = '{OFS_SEPARATION_HIGH, 8'hFF, 8'h07};
        rows[2] = '{OFS_SYNTH_CONTROL, 8'h1F, 8'h1C};
        rows[3] = '{OFS_LOCK_STATUS, 8'hFB, 8'h08};
        rows[4] = '{8'hE5, 8'hFF, 8'h00};
        rows[5] = '{8'hEC, 8'h5A, 8'h00};
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        check("sep_rst", {5'h00, separation_word}, 16'h0059);
        check("div_rst", {11'h000, reference_divider}, 16'h0002);
        rd_chk("low_rst", OFS_SEPARATION_LOW, 8'h59);
        rd_chk("high_rst", OFS_SEPARATION_HIGH, 8'h00);
        rd_chk("ctrl_rst", OFS_SYNTH_CONTROL, 8'h10);
        rd_chk("lock_rst", OFS_LOCK_STATUS, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 6; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk("table_read", rows[i].addr, rows[i].rdata);
        end
        check("sep_word", {5'h00, separation_word}, 16'h07A5);
        check("div_out", {11'h000, reference_divider}, 16'h0003);
        $display("test register table done");

        wr(OFS_SYNTH_CONTROL, 8'h10);
        tune_high_pin <= 1'b1;
        cycles(5);
        rd_chk("alarm_high", OFS_SYNTH_CONTROL, 8'h12);
        wr(OFS_SYNTH_CONTROL, 8'h14);
        rd_chk("alarm_masked", OFS_SYNTH_CONTROL, 8'h14);
        wr(OFS_SYNTH_CONTROL, 8'h13);
        rd_chk("alarm_ro", OFS_SYNTH_CONTROL, 8'h12);
        tune_high_pin <= 1'b0;
        tune_low_pin <= 1'b1;
        cycles(5);
        rd_chk("alarm_low", OFS_SYNTH_CONTROL, 8'h11);
        tune_low_pin <= 1'b0;
        $display("test tuning alarms done");

        @(posedge mclk);
        tx_mode <= 1'b1;
        transmit_bit <= 1'b1;
        cycles(2);
        check("offset_one", {5'h00, freq_offset}, 16'h07A5);
        transmit_bit <= 1'b0;
        cycles(2);
        check("offset_zero", {5'h00, freq_offset}, 16'h0000);
        tx_mode <= 1'b0;
        transmit_bit <= 1'b1;
        cycles(2);
        check("offset_rx", {5'h00, freq_offset}, 16'h0000);
        transmit_bit <= 1'b0;
        $display("test frequency offset done");

        wr(OFS_SYNTH_CONTROL, 8'h28);
        cycles(12);
        n = 0;
        for (int i = 0; i < 40 && ref_tick !== 1'b1; i++) begin
            cycles(1);
        end
        for (int i = 0; i < 40; i++) begin
            cycles(1);
            n++;
            if (ref_tick === 1'b1) begin
                break;
            end
        end
        check("tick_gap", n[15:0], 16'h0005);
        wr(OFS_SYNTH_CONTROL, 8'h10);
        $display("test reference tick done");

        wr(OFS_LOCK_STATUS, 8'h08);
        lock_window_pin <= 1'b1;
        ticks_until(1'b1, n);
        check("coarse_set", {15'h0000, n >= 31 && n <= 33}, 16'h0001);
        rd_chk("lock_both", OFS_LOCK_STATUS, 8'h0B);
        lock_window_pin <= 1'b0;
        ticks_until(1'b0, n);
        check("coarse_clr", {15'h0000, n >= 17 && n <= 19}, 16'h0001);
        rd_chk("lock_none", OFS_LOCK_STATUS, 8'h08);
        wr(OFS_LOCK_STATUS, 8'h00);
        // drain the filter count to zero
        cycles(40);
        lock_window_pin <= 1'b1;
        ticks_until(1'b1, n);
        check("fine_set", {15'h0000, n >= 127 && n <= 129}, 16'h0001);
        lock_window_pin <= 1'b0;
        ticks_until(1'b0, n);
        check("fine_clr", {15'h0000, n >= 17 && n <= 19}, 16'h0001);
        $display("test lock filter done");

        // back-to-back write and read, upper separation bits
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= OFS_SEPARATION_HIGH;
        reg_wdata <= 8'hFD;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check("high_b2b", {8'h00, reg_rdata}, 16'h0005);
        $display("test back to back access done");

        // continuous flag up before the second reset
        wr(OFS_LOCK_STATUS, 8'h08);
        lock_window_pin <= 1'b1;
        ticks_until(1'b1, n);
        wr(OFS_SEPARATION_LOW, 8'h3C);
        @(posedge mclk);
        nrst <= 1'b0;
        cycles(2);
        check("sep_mid_rst", {5'h00, separation_word}, 16'h0059);
        check("cont_mid_rst", {15'h0000, lock_continuous}, 16'h0000);
        nrst <= 1'b1;
        rd_chk("high_mid_rst", OFS_SEPARATION_HIGH, 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule
